// ### design/rsar_regs.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef RSAR_REGS_SVH
`define RSAR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RSAR_OFS_CEILING 8'h02
`define RSAR_OFS_STATUS 8'h04
`define RSAR_OFS_MASK 8'h05
`define RSAR_OFS_TARGET 8'h07

// ****************************************************************
// Reset values
// ****************************************************************
`define RSAR_RST_CEILING 7'h51
`define RSAR_RST_TARGET 7'h33
`define RSAR_RST_MASK 5'h00
`define RSAR_RST_CNT 12'h000

// ****************************************************************
// Field positions of the status, mask, ceiling and target registers
// ****************************************************************
`define RSAR_BIT_SUMMARY 0
`define RSAR_BIT_VIOL 1
`define RSAR_BIT_CURRENT 2
`define RSAR_BIT_HIGH 3
`define RSAR_BIT_LOW 4
`define RSAR_BIT_HOT 5
`define RSAR_CODE_MSB 6
`define RSAR_FLAG_MSB 5
`define RSAR_FLAG_LSB 1

// ****************************************************************
// Timing, with the clock period in ns
// ****************************************************************
`define RSAR_CLK_PERIOD_NS 50
`define RSAR_MOVE_DELAY_NS 500
`define RSAR_LOW_HOLD_NS 200000
`define RSAR_MOVE_DELAY_CYC \
    ((`RSAR_MOVE_DELAY_NS + `RSAR_CLK_PERIOD_NS - 1) / `RSAR_CLK_PERIOD_NS)
`define RSAR_LOW_HOLD_CYC \
    ((`RSAR_LOW_HOLD_NS + `RSAR_CLK_PERIOD_NS - 1) / `RSAR_CLK_PERIOD_NS)

`endif

// ### design/rsar_pkg.sv
// Types shared by the regulator status and alert register logic.
package rsar_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [6:0] rsar_code_t;
    typedef logic [4:0] rsar_flags_t;
    typedef logic [11:0] rsar_cnt_t;

    typedef enum logic
    {
        RSAR_MOVE_IDLE = 1'b0,
        RSAR_MOVE_WAIT = 1'b1
    } rsar_move_t;

endpackage : rsar_pkg

// ### design/rsar_persist.sv
// Persistence timer: a level that must stand for a number of cycles.
`timescale 1ns/10ps
`default_nettype none
`include "rsar_regs.svh"

module rsar_persist
#(
    parameter rsar_pkg::rsar_cnt_t HOLD = 12'h001
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Condition in and qualified level out.
    input wire logic cond,
    output logic held
);

    rsar_pkg::rsar_cnt_t cnt_reg;
    rsar_pkg::rsar_cnt_t cnt_next;

    // ************************************************************
    // Counter
    // ************************************************************

    // Any drop of the condition restarts the wait from zero.
    always_comb
    begin
        if (!cond)
            cnt_next = `RSAR_RST_CNT;
        else if (cnt_reg == HOLD)
            cnt_next = cnt_reg;
        else
            cnt_next = cnt_reg + 12'h001;
    end

    // Registers only.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_reg <= `RSAR_RST_CNT;
        else
            cnt_reg <= cnt_next;
    end

    // The level holds while the condition keeps standing.
    assign held = cond && (cnt_reg == HOLD);

endmodule : rsar_persist
`default_nettype wire

// ### design/rsar_top.sv
// Status, alert mask and output ceiling registers of the regulator.
//
// Contract
// [RULE_01] Target above ceiling regulates to the ceiling.
// [RULE_02] Ceiling resets to the 1.3 V code.
// [RULE_03] Ceiling is seven bits; bit seven reads zero.
// [RULE_04] Summary bit marks any unmasked flag present; the code drives it low then, as the NOR of the gated flags.
// [RULE_05] Hot flag follows the low temperature sense.
// [RULE_06] Low-output flag after 200 us below target.
// [RULE_07] High-output flag on over-target or fixed level.
// [RULE_08] Current flag when valley exceeds alarm level.
// [RULE_09] Violation flag while target exceeds the ceiling.
// [RULE_10] Mask gates alert only, never the flag.
// [RULE_11] Current flag sticky until status is read.
// [RULE_12] Ended current event no longer holds alert.
// [RULE_13] All other flags follow their live condition.
// [RULE_14] Summary is NOR of gated flags, drives alert.
// [RULE_15] Flag ANDed with inverted mask; mask bits 5:1.
// [RULE_16] Master reads status after alert goes low.
// [RULE_17] Regulation moves 0.5 us after target write.
// [RULE_18] Alert low while any unmasked flag stands.
`timescale 1ns/10ps
`default_nettype none
`include "rsar_regs.svh"

module rsar_top
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic ARST_N,
    // Decoded register access from the serial interface engine.
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Detector levels from the analog side.
    input wire logic TEMP_SENSE_LOW,
    input wire logic OUT_BELOW_TARGET,
    input wire logic OUT_ABOVE_TARGET,
    input wire logic OUT_ABOVE_FIXED,
    input wire logic CURRENT_ALARM,
    // Regulation goal and alert pin.
    output logic [6:0] EFFECTIVE_CODE,
    output logic MOVE_START,
    output logic ALERT_N
);

    // ************************************************************
    // Declarations
    // ************************************************************
    rsar_pkg::rsar_code_t ceiling_reg, ceiling_next;
    rsar_pkg::rsar_code_t target_reg, target_next;
    rsar_pkg::rsar_code_t applied_reg, applied_next;
    rsar_pkg::rsar_code_t effective_reg, effective_next;
    rsar_pkg::rsar_flags_t mask_reg, mask_next;
    rsar_pkg::rsar_flags_t gated;
    rsar_pkg::rsar_move_t move_reg, move_next;
    rsar_pkg::rsar_cnt_t delay_reg, delay_next;
    logic move_start_reg, move_start_next;
    logic hot_reg, hot_next;
    logic high_reg, high_next;
    logic viol_reg, viol_next;
    logic cur_live_reg, cur_live_next;
    logic cur_sticky_reg, cur_sticky_next;
    logic low_flag;
    logic summary;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] status_value;
    logic wr_ceiling, wr_mask, wr_target, rd_status;

    localparam rsar_pkg::rsar_cnt_t LOW_HOLD = 12'(`RSAR_LOW_HOLD_CYC);
    localparam rsar_pkg::rsar_cnt_t MOVE_LOAD = 12'(`RSAR_MOVE_DELAY_CYC - 1);

    // ************************************************************
    // Address decode
    // ************************************************************
    assign wr_ceiling = REG_WR && (REG_ADDR == `RSAR_OFS_CEILING);
    assign wr_mask = REG_WR && (REG_ADDR == `RSAR_OFS_MASK);
    assign wr_target = REG_WR && (REG_ADDR == `RSAR_OFS_TARGET);
    assign rd_status = REG_RD && (REG_ADDR == `RSAR_OFS_STATUS);

    // ************************************************************
    // Configuration registers
    // ************************************************************

    // Bit seven of code writes is dropped here. see [RULE_03]
    always_comb
    begin
        ceiling_next = ceiling_reg;
        target_next = target_reg;
        mask_next = mask_reg;
        if (wr_ceiling)
            ceiling_next = REG_WDATA[`RSAR_CODE_MSB:0]; // see [RULE_03]
        if (wr_target)
            target_next = REG_WDATA[`RSAR_CODE_MSB:0];
        if (wr_mask)
            mask_next = REG_WDATA[`RSAR_FLAG_MSB:`RSAR_FLAG_LSB]; // see [RULE_15]
    end

    // Ceiling comes up at the 1.3 V code. see [RULE_02]
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ceiling_reg <= `RSAR_RST_CEILING;
            target_reg <= `RSAR_RST_TARGET;
            mask_reg <= `RSAR_RST_MASK;
        end
        else
        begin
            ceiling_reg <= ceiling_next;
            target_reg <= target_next;
            mask_reg <= mask_next;
        end
    end

    // ************************************************************
    // Move timing and clamped goal
    // ************************************************************

    // A new write restarts the wait, so only the last target moves.
    // The clamp is reapplied every cycle, so a lowered ceiling also
    // pulls a goal already in force down to it.
    always_comb
    begin
        move_next = move_reg;
        delay_next = delay_reg;
        move_start_next = 1'b0;
        applied_next = applied_reg;
        if (wr_target)
        begin
            move_next = rsar_pkg::RSAR_MOVE_WAIT; // see [RULE_17]
            delay_next = MOVE_LOAD;
        end
        else
        begin
            unique case (move_reg)
                rsar_pkg::RSAR_MOVE_IDLE:
                    delay_next = delay_reg;
                rsar_pkg::RSAR_MOVE_WAIT:
                    if (delay_reg <= 12'h001)
                    begin
                        move_next = rsar_pkg::RSAR_MOVE_IDLE;
                        move_start_next = 1'b1; // see [RULE_17]
                        applied_next = target_reg;
                    end
                    else
                        delay_next = delay_reg - 12'h001;
            endcase
        end
        if (applied_next > ceiling_next)
            effective_next = ceiling_next; // see [RULE_01]
        else
            effective_next = applied_next;
    end

    // Registers only.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            move_reg <= rsar_pkg::RSAR_MOVE_IDLE;
            delay_reg <= `RSAR_RST_CNT;
            move_start_reg <= 1'b0;
            applied_reg <= `RSAR_RST_TARGET;
            effective_reg <= `RSAR_RST_TARGET;
        end
        else
        begin
            move_reg <= move_next;
            delay_reg <= delay_next;
            move_start_reg <= move_start_next;
            applied_reg <= applied_next;
            effective_reg <= effective_next;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************

    // The low-output detector must persist before it counts.
    rsar_persist
    #(
        .HOLD(LOW_HOLD)
    )
    u_low_hold
    (
        .clk(CLK),
        .arst_n(ARST_N),
        .cond(OUT_BELOW_TARGET),
        .held(low_flag) // see [RULE_06]
    );

    // Live flags track their detectors; only the current flag latches.
    // An alarm in the same cycle as a status read keeps the flag set.
    always_comb
    begin
        hot_next = TEMP_SENSE_LOW; // see [RULE_05] see [RULE_13]
        high_next = OUT_ABOVE_TARGET || OUT_ABOVE_FIXED; // see [RULE_07]
        viol_next = target_reg > ceiling_reg; // see [RULE_09]
        cur_live_next = CURRENT_ALARM; // see [RULE_08]
        if (CURRENT_ALARM)
            cur_sticky_next = 1'b1; // see [RULE_11]
        else if (rd_status)
            cur_sticky_next = 1'b0; // see [RULE_11]
        else
            cur_sticky_next = cur_sticky_reg;
    end

    // Registers only.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            hot_reg <= 1'b0;
            high_reg <= 1'b0;
            viol_reg <= 1'b0;
            cur_live_reg <= 1'b0;
            cur_sticky_reg <= 1'b0;
        end
        else
        begin
            hot_reg <= hot_next;
            high_reg <= high_next;
            viol_reg <= viol_next;
            cur_live_reg <= cur_live_next;
            cur_sticky_reg <= cur_sticky_next;
        end
    end

    // ************************************************************
    // Masking and alert
    // ************************************************************

    // The current term uses the live alarm, so a past event that is
    // only latched does not keep the pin low. The mask never touches
    // the stored flags.
    assign gated = {hot_reg, low_flag, high_reg, cur_live_reg, viol_reg}
        & ~mask_reg; // see [RULE_15] see [RULE_12] see [RULE_10]
    assign summary = ~|gated; // see [RULE_14] see [RULE_04]
    assign ALERT_N = summary; // see [RULE_18]

    assign status_value = {2'b00, hot_reg, low_flag, high_reg,
        cur_sticky_reg, viol_reg, summary}; // see [RULE_10]

    // ************************************************************
    // Read data
    // ************************************************************

    // Unmapped and reserved locations read as zero.
    always_comb
    begin
        rdata_next = rdata_reg;
        if (REG_RD)
        begin
            unique case (REG_ADDR)
                `RSAR_OFS_CEILING:
                    rdata_next = {1'b0, ceiling_reg}; // see [RULE_03]
                `RSAR_OFS_STATUS:
                    rdata_next = status_value; // see [RULE_16]
                `RSAR_OFS_MASK:
                    rdata_next = {2'b00, mask_reg, 1'b0}; // see [RULE_15]
                `RSAR_OFS_TARGET:
                    rdata_next = {1'b0, target_reg};
                default:
                    rdata_next = 8'h00;
            endcase
        end
    end

    // Registers only.
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign REG_RDATA = rdata_reg;
    assign EFFECTIVE_CODE = effective_reg;
    assign MOVE_START = move_start_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking rsar_cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    sequence target_write_s;
        REG_WR && (REG_ADDR == `RSAR_OFS_TARGET);
    endsequence

    // Eight quiet cycles plus one more cover the whole ten-cycle wait.
    sequence quiet_wait_s;
        !wr_target [*8];
    endsequence

    move_delay_a: assert property ( // see [RULE_17]
        target_write_s ##1 quiet_wait_s ##1 !wr_target |=> MOVE_START &&
        EFFECTIVE_CODE <= $past(target_reg, 2))
        else $error("Move did not start ten cycles after the write.");

    move_early_a: assert property ( // see [RULE_17]
        target_write_s |=> !MOVE_START [*8])
        else $error("Move started before the delay elapsed.");

    clamp_goal_a: assert property ( // see [RULE_01]
        MOVE_START && ($past(target_reg) > $past(ceiling_reg)) |->
        EFFECTIVE_CODE == $past(ceiling_reg))
        else $error("Goal above the ceiling was not clamped.");

    ceiling_read_a: assert property ( // see [RULE_03]
        REG_RD && (REG_ADDR == `RSAR_OFS_CEILING) |=>
        REG_RDATA == {1'b0, $past(ceiling_reg)})
        else $error("Ceiling read back wrong or bit seven set.");

    hot_follow_a: assert property ( // see [RULE_05]
        TEMP_SENSE_LOW ##1 !TEMP_SENSE_LOW |=> !status_value[5])
        else $error("Hot flag latched or lagged its input.");

    high_follow_a: assert property ( // see [RULE_07]
        (OUT_ABOVE_TARGET || OUT_ABOVE_FIXED) |=> status_value[3])
        else $error("High-output flag missed its detector.");

    low_persist_a: assert property ( // see [RULE_06]
        $rose(low_flag) |-> $past(OUT_BELOW_TARGET, 8) && OUT_BELOW_TARGET)
        else $error("Low-output flag rose without persistence.");

    viol_track_a: assert property ( // see [RULE_09]
        (target_reg > ceiling_reg) |=> viol_reg)
        else $error("Violation flag missing while target too high.");

    current_keep_a: assert property ( // see [RULE_11]
        cur_sticky_reg && !rd_status |=> cur_sticky_reg)
        else $error("Current flag dropped without a status read.");

    current_clear_a: assert property ( // see [RULE_11]
        rd_status && !CURRENT_ALARM |=> !cur_sticky_reg)
        else $error("Current flag not cleared by the status read.");

    // Only the latched current bit stands, so the pin must be released.
    alert_release_a: assert property ( // see [RULE_12]
        cur_sticky_reg && !cur_live_reg && !hot_reg && !low_flag &&
        !high_reg && !viol_reg |-> ALERT_N)
        else $error("Latched current flag still holds the alert.");

    // A mask write in the same cycle may hide the alarm a cycle later.
    alert_unmasked_a: assert property ( // see [RULE_18] see [RULE_10]
        CURRENT_ALARM && !mask_reg[1] && !wr_mask |=>
        !ALERT_N && status_value[2])
        else $error("Unmasked current alarm did not pull alert low.");

endmodule : rsar_top
`default_nettype wire

// ### testbench/rsar_master.sv
// Register bus master model that issues single-byte accesses.
`timescale 1ns/10ps
`default_nettype none

module rsar_master
(
    // Clock.
    input wire logic clk,
    // Register access strobes, address and data.
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    localparam int DLY = 2;

    // Idle bus: strobes low, address and data lines scrambled.
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hA5;
        reg_wdata = 8'h5A;
    end

    // One strobe per byte. Lines are inverted once released, so a design
    // that samples outside the strobe sees garbage rather than old data.
    task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #DLY;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk);
        #DLY;
        reg_wr = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask : bus_write

    // Read data is taken one edge after the strobe edge, where it stands.
    task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        #DLY;
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge clk);
        #DLY;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        @(posedge clk);
        #DLY;
        data = reg_rdata;
    endtask : bus_read

endmodule : rsar_master

`default_nettype wire

// ### testbench/tb.sv
// Self-checking testbench of the regulator status and alert registers.
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam int DLY = 2;
    logic clk;
    logic arst_n;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic hot, below, above_t, above_f, alarm;
    logic [6:0] eff_code;
    logic move_start;
    logic alert_n;
    logic [7:0] rdata;
    int errors = 0;
    int checked = 0;
    int since = 1000;
    // Reference model state.
    int m_ceil = 'h51;
    int m_tgt = 'h33;
    logic [4:0] m_mask = 5'h00;
    logic m_sticky = 1'b0;
    logic m_low = 1'b0;

    rsar_master u_rsar_master (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    rsar_top u_rsar_top (.CLK(clk), .ARST_N(arst_n), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .TEMP_SENSE_LOW(hot),
        .OUT_BELOW_TARGET(below), .OUT_ABOVE_TARGET(above_t),
        .OUT_ABOVE_FIXED(above_f), .CURRENT_ALARM(alarm),
        .EFFECTIVE_CODE(eff_code), .MOVE_START(move_start),
        .ALERT_N(alert_n));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Summary uses the live alarm; the sticky bit only shows in status.
    function automatic logic [7:0] exp_read(input logic [7:0] addr);
        logic [4:0] live;
        logic [7:0] st;
        live = {hot, m_low, above_t | above_f, alarm, 1'(m_tgt > m_ceil)};
        st = {2'b00, live[4:2], live[1] | m_sticky, live[0],
              ~|(live & ~m_mask)};
        case (addr)
            8'h02: exp_read = {1'b0, 7'(m_ceil)};
            8'h04: exp_read = st;
            8'h05: exp_read = {2'b00, m_mask, 1'b0};
            8'h07: exp_read = {1'b0, 7'(m_tgt)};
            default: exp_read = 8'h00;
        endcase
    endfunction : exp_read

    // The goal in force is the target clamped to the ceiling.
    function automatic logic [7:0] exp_goal();
        exp_goal = 8'(m_tgt < m_ceil ? m_tgt : m_ceil);
    endfunction : exp_goal

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        if (addr == 8'h02) m_ceil = int'(data[6:0]);
        if (addr == 8'h05) m_mask = data[5:1];
        if (addr == 8'h07) m_tgt = int'(data[6:0]);
        u_rsar_master.bus_write(addr, data);
    endtask : wr

    // A status read also checks the alert pin against the summary bit.
    task automatic rd(input logic [7:0] addr);
        logic [7:0] exp;
        exp = exp_read(addr);
        u_rsar_master.bus_read(addr, rdata);
        chk(rdata, exp);
        if (addr == 8'h04)
        begin
            chk({7'h00, alert_n}, {7'h00, exp[0]});
            if (!alarm) m_sticky = 1'b0;
        end
    endtask : rd

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask : cycles

    task automatic summarize();
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // ****************************************************************
    // Clock, model tracking and watchdog
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // The sticky flag and the move delay are tracked edge by edge.
    always @(posedge clk)
    begin
        if (alarm === 1'b1) m_sticky = 1'b1;
        since = since + 1;
        if (reg_wr === 1'b1 && reg_addr === 8'h07) since = 0;
        if (move_start === 1'b1)
        begin
            chk(8'(since), 8'd10);
            chk({1'b0, eff_code}, exp_goal());
        end
    end

    // A hang costs a mismatch; the run is sized near 4300 cycles, the limit at 20000.
    initial
    begin
        #(20000 * 50);
        errors++;
        summarize();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        {arst_n, hot, below, above_t, above_f, alarm} = 6'b000000;
        void'($urandom(32'h60f7));
        cycles(12);
        arst_n = 1'b1;
        chk({1'b0, eff_code}, 8'h33);
        // Reset values and unmapped offsets.
        for (int a = 0; a < 9; a++)
            rd(8'(a));
        // Bit seven dropped; status is not writable.
        wr(8'h02, 8'hFF);
        rd(8'h02);
        wr(8'h04, 8'hFF);
        rd(8'h04);
        // Target over the ceiling is clamped and flagged, then cleared.
        wr(8'h02, 8'h40);
        wr(8'h07, 8'h55);
        cycles(14);
        chk({7'h00, alert_n}, 8'h00);
        rd(8'h04);
        wr(8'h07, 8'h30);
        cycles(14);
        rd(8'h04);
        // Lowering the ceiling clamps the goal at once.
        wr(8'h02, 8'h20);
        cycles(2);
        chk({1'b0, eff_code}, 8'h20);
        wr(8'h02, 8'h51);
        // Random detector levels against random masks.
        for (int i = 0; i < 16; i++)
        begin
            {hot, above_t, above_f, alarm} = 4'($urandom);
            wr(8'h05, 8'($urandom));
            cycles(3);
            rd(8'h04);
            rd(8'h05);
        end
        // Current alarm latches in status but releases the alert.
        {hot, above_t, above_f, alarm} = 4'h0;
        wr(8'h05, 8'h00);
        rd(8'h04);
        alarm = 1'b1;
        cycles(3);
        chk({7'h00, alert_n}, 8'h00);
        alarm = 1'b0;
        cycles(3);
        chk({7'h00, alert_n}, 8'h01);
        rd(8'h04);
        rd(8'h04);
        // Low output exactly after 4000 edges, then follows the input.
        below = 1'b1;
        cycles(3999);
        chk({7'h00, alert_n}, 8'h01);
        cycles(1);
        chk({7'h00, alert_n}, 8'h00);
        cycles(10);
        m_low = 1'b1;
        rd(8'h04);
        below = 1'b0;
        cycles(3);
        m_low = 1'b0;
        rd(8'h04);
        summarize();
    end

endmodule : tb

`default_nettype wire
